// *** shared/ccc_pkg.sv ***
// Constants, types and register map of the compare, complement and issue unit.
package ccc_pkg;

  // Register map, byte addresses of 32-bit words.
  localparam logic [7:0] OFS_GPR_BASE = 8'h00;
  localparam logic [7:0] OFS_EXT_BASE = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h60;
  localparam logic [7:0] OFS_INSTR = 8'h64;
  localparam logic [7:0] OFS_CMD = 8'h68;

  // Register file sizes and the loop-counter register numbers.
  localparam int GPR_COUNT = 16;
  localparam int EXT_COUNT = 8;
  localparam int COND_COUNT = 4;
  localparam logic [3:0] LOOP_REG_A = 4'h6;
  localparam logic [3:0] LOOP_REG_B = 4'h7;

  // Reset values.
  localparam logic [15:0] RST_GPR = 16'h0000;
  localparam logic [5:0] RST_EXT = 6'h00;
  localparam logic [12:0] RST_CMD = 13'h0000;

  // Lowest command value that programs are expected to issue.
  localparam logic [12:0] ISSUE_MIN_CMD = 13'h0200;

  // Compare condition codes; 5 to 7 are undefined.
  typedef enum logic [2:0] {
    SIGNED_GE_COND = 3'h0,
    SIGNED_GT_COND = 3'h1,
    UNSIGNED_GE_COND = 3'h2,
    UNSIGNED_GT_COND = 3'h3,
    EQUAL_COND = 3'h4
  } cond_e;

  // Complement modes; 3 is undefined.
  localparam logic [1:0] ONES_COMPLEMENT_OP = 2'h0;
  localparam logic [1:0] TWOS_COMPLEMENT_OP = 2'h1;
  localparam logic [1:0] CARRY_COMPLEMENT_OP = 2'h2;

  // Instruction fetch state.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WORD2 = 2'b10
  } fetch_e;

  // Status word layout, low bits of the status register.
  typedef struct packed {
    logic waitSecond;
    logic [3:0] extCond;
    logic spare;
    logic loopZeroB;
    logic loopZeroA;
    logic testFlag;
  } status_s;

endpackage : ccc_pkg

// *** design/compare_complement_coproc_issue.sv ***
// Compare, complement and coprocessor-issue execution unit with bus slave.
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/100ps
module compare_complement_coproc_issue
  import ccc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Avalon-MM register slave.
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Coprocessor side.
  output logic [12:0] coprocCommandBus,
  output logic coprocCommandStrobe_n,
  input wire logic [COND_COUNT-1:0] extCondIn
);

  // The decoder needs byte addresses up to the command register.
  if (ADDR_W < 7 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must be 7 or 8");
  end

  logic [GPR_COUNT-1:0][15:0] gpr;
  logic [EXT_COUNT-1:0][5:0] ext;
  logic testFlag;
  logic loopZeroA;
  logic loopZeroB;
  fetch_e state;
  fetch_e next_state;
  logic [15:0] pendWord;
  logic [COND_COUNT-1:0] condMeta;
  logic [COND_COUNT-1:0] condSync;
  logic next_testFlag;
  logic [31:0] next_readData;
  status_s statusView;

  // Bus decode. A request is accepted at the edge where waitrequest is low.
  wire [7:0] byteAddr = 8'(address);
  wire acceptWr = write && !waitrequest;
  wire [15:0] wdata16 = writedata[15:0];
  wire gprSel = byteAddr[7:6] == OFS_GPR_BASE[7:6];
  wire extSel = byteAddr[7:5] == OFS_EXT_BASE[7:5];
  wire statusSel = {byteAddr[7:2], 2'b00} == OFS_STATUS;
  wire instrSel = {byteAddr[7:2], 2'b00} == OFS_INSTR;
  wire cmdSel = {byteAddr[7:2], 2'b00} == OFS_CMD;
  wire [3:0] gprIdx = byteAddr[5:2];
  wire [2:0] extIdx = byteAddr[4:2];
  wire gprBusWr = acceptWr && gprSel;
  wire extBusWr = acceptWr && extSel && byteenable[0];
  wire statusWr = acceptWr && statusSel && byteenable[0];
  wire instrWrite = acceptWr && instrSel;
  wire [15:0] gprMerged = {byteenable[1] ? wdata16[15:8] : gpr[gprIdx][15:8],
                           byteenable[0] ? wdata16[7:0] : gpr[gprIdx][7:0]};

  // Opcode decode. In the second fetch the held first word is decoded and
  // the bus word is the trailing immediate.
  wire inWord2 = state == ST_WORD2;
  wire [15:0] cur = inWord2 ? pendWord : wdata16;
  wire isCmpImm = cur[15:11] == 5'h11 && cur[7:4] == 4'hF;
  wire isCpl = cur[15:10] == 6'h23 && cur[7:4] == 4'hE;
  wire isCmpReg = cur[15:12] == 4'h8 && cur[7] && !isCmpImm && !isCpl;
  wire isCmpShort = cur[15:11] == 5'h14 && cur[7:6] == 2'b01;
  wire isEqLarge = cur[15:11] == 5'h14 && cur[7:6] == 2'b10;
  wire isEqAddr = cur[15:11] == 5'h15 && cur[7:3] == 5'h02;
  wire isEqSmall = cur[15:11] == 5'h12;
  wire isIssue = cur[15:13] == 3'h7;
  wire twoWord = isCmpImm || isEqLarge;
  wire startTwo = instrWrite && !inWord2 && twoWord;
  wire execute = instrWrite && (inWord2 || !twoWord);

  // Generic compare datapath, shared by register and 16-bit immediate forms.
  // The difference is formed as a + ~b + 1 so bit 16 is the no-borrow carry.
  wire [2:0] cmpCond = isCmpReg ? cur[6:4] : cur[10:8];
  wire [15:0] cmpA = gpr[isCmpReg ? cur[11:8] : cur[3:0]];
  wire [15:0] cmpB = isCmpReg ? gpr[cur[3:0]] : wdata16;
  wire [16:0] cmpSum = {1'b0, cmpA} + {1'b0, ~cmpB} + 17'h0_0001;
  wire cmpNeg = cmpSum[15];
  wire cmpCarry = cmpSum[16];
  wire cmpZero = cmpSum[15:0] == 16'h0000;
  logic condResult;
  logic condValid;

  // Condition selection; undefined codes leave the flag alone.
  always_comb begin
    condResult = 1'b0;
    condValid = 1'b1;
    case (cmpCond)
      SIGNED_GE_COND: condResult = !cmpNeg;
      SIGNED_GT_COND: condResult = !cmpNeg && !cmpZero;
      UNSIGNED_GE_COND: condResult = cmpCarry;
      UNSIGNED_GT_COND: condResult = cmpCarry && !cmpZero;
      EQUAL_COND: condResult = cmpZero;
      default: condValid = 1'b0;
    endcase
  end

  // Short and small-immediate forms use the low eight registers only.
  wire [15:0] lowVal = gpr[{1'b0, cur[10:8]}];
  wire [15:0] shortDiff = lowVal - {10'h000, cur[5:0]};
  wire smallEq = lowVal == {8'h00, cur[7:0]};

  // 22-bit address registers are the upper eight registers plus extension.
  wire [21:0] addrN = {ext[cur[10:8]], gpr[{1'b1, cur[10:8]}]};
  wire [21:0] addrI = {ext[cur[2:0]], gpr[{1'b1, cur[2:0]}]};
  wire [21:0] largeImm = {cur[5:0], wdata16};
  wire [21:0] largeDiff = addrN - largeImm;
  wire addrEq = addrN == addrI;

  // Complement datapath. The carry-in is 1, the test flag or 0 by mode.
  wire [3:0] cplIdx = cur[3:0];
  wire [1:0] cplMode = cur[9:8];
  wire cplValid = cplMode != 2'b11;
  wire [15:0] cplInv = ~gpr[cplIdx];
  wire cplCarryIn = (cplMode == TWOS_COMPLEMENT_OP) ||
                    (cplMode == CARRY_COMPLEMENT_OP && testFlag);
  wire [16:0] cplSum = {1'b0, cplInv} + {16'h0000, cplCarryIn};
  wire [15:0] cplResult = cplSum[15:0];
  wire cplZero = cplResult == 16'h0000;
  wire cplWr = execute && isCpl && cplValid;
  wire doIssue = execute && isIssue;

  // Next test flag. Software writes and instruction execution come from
  // different bus accesses, so they can never meet in one cycle.
  always_comb begin
    next_testFlag = testFlag;
    if (statusWr) begin
      next_testFlag = writedata[0];
    end else if (execute) begin
      if ((isCmpReg || isCmpImm) && condValid) begin
        next_testFlag = condResult;
      end else if (isCmpShort) begin
        next_testFlag = !shortDiff[15];
      end else if (isEqAddr) begin
        next_testFlag = addrEq;
      end else if (isEqSmall) begin
        next_testFlag = smallEq;
      end else if (isEqLarge) begin
        next_testFlag = largeDiff == 22'h00_0000;
      end else if (cplWr) begin
        // Ones complement tests the result, the others take the carry.
        next_testFlag = cplMode == ONES_COMPLEMENT_OP ? cplZero
          : cplSum[16];
      end
    end
  end

  // Fetch sequencing: a two-word instruction holds its first word.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (startTwo) next_state = ST_WORD2;
      ST_WORD2: if (instrWrite) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Read data mux; unmapped addresses read as zero.
  assign statusView = '{waitSecond: inWord2, extCond: condSync,
                        spare: 1'b0, loopZeroB: loopZeroB,
                        loopZeroA: loopZeroA, testFlag: testFlag};
  always_comb begin
    next_readData = 32'h0000_0000;
    if (gprSel) begin
      next_readData = {16'h0000, gpr[gprIdx]};
    end else if (extSel) begin
      next_readData = {26'h000_0000, ext[extIdx]};
    end else if (statusSel) begin
      next_readData = {23'h00_0000, statusView};
    end else if (instrSel) begin
      next_readData = {16'h0000, pendWord};
    end else if (cmdSel) begin
      next_readData = {19'h0_0000, coprocCommandBus};
    end
  end

  // Every access waits exactly one cycle, which keeps read data registered.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      readdata <= next_readData;
    end
  end

  // General registers: bus writes, or complement results written back.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gpr <= {GPR_COUNT{RST_GPR}};
    end else if (gprBusWr) begin
      gpr[gprIdx] <= gprMerged;
    end else if (cplWr) begin
      gpr[cplIdx] <= cplResult;
    end
  end

  // Address extensions are only ever changed by software.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext <= {EXT_COUNT{RST_EXT}};
    end else if (extBusWr) begin
      ext[extIdx] <= writedata[5:0];
    end
  end

  // Flags and fetch state. Software must be able to clear the loop flags
  // before a loop starts, so they are writable through the status word.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      testFlag <= 1'b0;
      loopZeroA <= 1'b0;
      loopZeroB <= 1'b0;
      state <= ST_IDLE;
      pendWord <= 16'h0000;
    end else begin
      testFlag <= next_testFlag;
      state <= next_state;
      if (startTwo) pendWord <= wdata16;
      if (statusWr) begin
        loopZeroA <= writedata[1];
        loopZeroB <= writedata[2];
      end else if (cplWr && cplIdx == LOOP_REG_A) begin
        loopZeroA <= cplZero;
      end else if (cplWr && cplIdx == LOOP_REG_B) begin
        loopZeroB <= cplZero;
      end
    end
  end

  // Issue port. The command stays on the bus; the strobe is a one-cycle
  // low pulse. Values below ISSUE_MIN_CMD are not filtered, by design.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      coprocCommandBus <= RST_CMD;
      coprocCommandStrobe_n <= 1'b1;
    end else begin
      coprocCommandStrobe_n <= !doIssue;
      if (doIssue) coprocCommandBus <= cur[12:0];
    end
  end

  // Condition lines arrive from the coprocessor's own logic: two stages.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      condMeta <= '0;
      condSync <= '0;
    end else begin
      condMeta <= extCondIn;
      condSync <= condMeta;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Compares never touch the register files.
  cmp_keeps_regs_a: assert property (
    execute && (isCmpReg || isCmpImm || isCmpShort) |=>
      $stable(gpr) && $stable(ext))
    else $error("compare changed a register");

  sge_flag_a: assert property (
    execute && (isCmpReg || isCmpImm) && cmpCond == 3'h0 |=>
      testFlag == !$past(cmpNeg))
    else $error("signed ge flag wrong");

  unsigned_gt_a: assert property (
    execute && (isCmpReg || isCmpImm) && cmpCond == 3'h3 |=>
      testFlag == $past(cmpCarry && !cmpZero))
    else $error("unsigned gt flag wrong");

  two_word_wait_a: assert property (
    startTwo |=> inWord2 && $stable(testFlag) && coprocCommandStrobe_n)
    else $error("first word did not wait for second");

  short_sign_a: assert property (
    execute && isCmpShort |=> testFlag == !$past(shortDiff[15]))
    else $error("short compare flag wrong");

  addr_equal_a: assert property (
    execute && isEqAddr |=> testFlag == $past(addrEq))
    else $error("address compare flag wrong");

  ones_comp_a: assert property (
    cplWr && cplMode == ONES_COMPLEMENT_OP |=>
      gpr[$past(cplIdx)] == ~$past(gpr[cplIdx])
      && testFlag == (gpr[$past(cplIdx)] == 16'h0000))
    else $error("ones complement wrong");

  loop_zero_a: assert property (
    cplWr && cplIdx == LOOP_REG_A |=>
      loopZeroA == (gpr[LOOP_REG_A] == 16'h0000))
    else $error("loop zero flag not updated");

  loop_zero_b_a: assert property (
    cplWr && cplIdx == LOOP_REG_B |=>
      loopZeroB == (gpr[LOOP_REG_B] == 16'h0000))
    else $error("second loop zero flag not updated");

  issue_strobe_a: assert property (
    doIssue |=> !coprocCommandStrobe_n
      && coprocCommandBus == $past(wdata16[12:0]) ##1 coprocCommandStrobe_n)
    else $error("issue strobe or command wrong");

  undef_noop_a: assert property (
    execute && isCpl && !cplValid |=>
      $stable(gpr) && $stable(testFlag) && $stable(loopZeroA))
    else $error("undefined complement mode acted");

endmodule : compare_complement_coproc_issue

// *** bench/coproc_model.sv ***
// Behavioural coprocessor that takes issued commands and raises conditions.
`timescale 1ns/100ps
module coproc_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic arst_n,
  // Command side of the core.
  input wire logic [12:0] coprocCommandBus,
  input wire logic coprocCommandStrobe_n,
  // Condition lines and observation of what was taken.
  output logic [3:0] extCondIn,
  output int issueCount,
  output logic [12:0] lastCmd
);
  // Every low strobe cycle counts, so a stretched pulse shows as extra counts.
  // The condition raised is chosen by the low command bits, as a real
  // coprocessor would pick it from the operation that it performed.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      issueCount <= 0;
      lastCmd <= 13'h0000;
      extCondIn <= 4'h0;
    end else if (coprocCommandStrobe_n === 1'b0) begin
      issueCount <= issueCount + 1;
      lastCmd <= coprocCommandBus;
      extCondIn <= 4'h1 << coprocCommandBus[1:0];
    end
  end
endmodule : coproc_model

// *** bench/compare_complement_coproc_issue_bench.sv ***
// Self-checking bench for the compare, complement and issue unit.
`timescale 1ns/100ps
module compare_complement_coproc_issue_bench
  import ccc_pkg::*;
;
  // Bus, design and partner wiring.
  logic clk_sys;
  logic arst_n;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [12:0] cmdBus;
  logic cmdStrobe_n;
  logic [3:0] extCond;
  int issueCount;
  logic [12:0] lastCmd;
  logic [31:0] q;
  int fails = 0;
  int checked = 0;
  int cycles = 0;

  // Unit under test; all lanes enabled since registers are full words.
  compare_complement_coproc_issue uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest),
    .coprocCommandBus(cmdBus), .coprocCommandStrobe_n(cmdStrobe_n),
    .extCondIn(extCond));

  // Far side of the issue port.
  coproc_model partner (
    .clk_sys(clk_sys), .arst_n(arst_n), .coprocCommandBus(cmdBus),
    .coprocCommandStrobe_n(cmdStrobe_n), .extCondIn(extCond),
    .issueCount(issueCount), .lastCmd(lastCmd));

  // Clock at 20 MHz.
  always #25 clk_sys = ~clk_sys;

  // Expected test flag; carry means no borrow in the subtraction.
  function automatic logic cmp_flag(logic [2:0] c, logic [15:0] a,
                                    logic [15:0] b);
    logic [16:0] df;
    df = {1'b0, a} - {1'b0, b};
    case (c)
      3'h0: return !df[15];
      3'h1: return !df[15] && df[15:0] != 16'h0000;
      3'h2: return !df[16];
      3'h3: return !df[16] && df[15:0] != 16'h0000;
      default: return df[15:0] == 16'h0000;
    endcase
  endfunction : cmp_flag

  function automatic logic [7:0] ga(int n);
    return OFS_GPR_BASE + 8'(4 * n);
  endfunction : ga

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One Avalon transfer; held until waitrequest is sampled low, then one
  // idle edge so that the next request never lands in the same time step.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do @(posedge clk_sys); while (waitrequest !== 1'b0);
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] j;
    bus(1'b1, a, d, j);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0000_0000, r);
  endtask : rd

  task exec(input logic [15:0] w);
    wr(OFS_INSTR, {16'h0000, w});
  endtask : exec

  // Preset the flag, run an instruction and check the flag it leaves.
  task flag_case(input logic [15:0] w1, input bit two, input logic [15:0] w2,
                 input logic p, input logic e);
    wr(OFS_STATUS, 32'(p));
    exec(w1);
    if (two) begin
      rd(OFS_STATUS, q);
      chk("second word wait", 32'h0000_0001, 32'(q[8]));
      exec(w2);
    end
    rd(OFS_STATUS, q);
    chk("test flag", 32'(e), 32'({q[8], q[0]}));
  endtask : flag_case

  task t_reset;
    rd(OFS_STATUS, q);
    chk("status reset", 32'h0000_0000, q);
    rd(ga(5), q);
    chk("register reset", 32'h0000_0000, q);
    rd(OFS_CMD, q);
    chk("command reset", 32'h0000_0000, q);
    wr(8'h70, 32'h0000_FFFF);
    rd(8'h70, q);
    chk("unmapped read", 32'h0000_0000, q);
  endtask : t_reset

  // Register and immediate compares over every code, undefined ones too.
  task t_compare;
    logic [15:0] a [3];
    logic [15:0] b [3];
    logic p;
    logic e;
    a = '{16'h8000, 16'h1234, 16'h0001};
    b = '{16'h0001, 16'h1234, 16'h0002};
    for (int i = 0; i < 3; i++) begin
      wr(ga(1), 32'(a[i]));
      wr(ga(2), 32'(b[i]));
      for (int c = 0; c < 8; c++) begin
        p = !cmp_flag(3'(c), a[i], b[i]);
        e = (c < 5) ? !p : p;
        flag_case({8'h81, 1'b1, 3'(c), 4'h2}, 0, 16'h0000, p, e);
        flag_case({5'h11, 3'(c), 8'hF1}, 1, b[i], p, e);
      end
      rd(ga(1), q);
      chk("first source", 32'(a[i]), q);
      rd(ga(2), q);
      chk("second source", 32'(b[i]), q);
    end
  endtask : t_compare

  // Short compare, then small, extended-register and large equality compares.
  task t_special;
    wr(ga(3), 32'h0000_0000);
    flag_case({5'h14, 3'h3, 2'h1, 6'h20}, 0, 16'h0000, 1, 0);
    wr(ga(3), 32'h0000_0105);
    flag_case({5'h12, 3'h3, 8'h05}, 0, 16'h0000, 1, 0);
    wr(ga(3), 32'h0000_0005);
    flag_case({5'h12, 3'h3, 8'h05}, 0, 16'h0000, 0, 1);
    flag_case({5'h14, 3'h3, 2'h1, 6'h05}, 0, 16'h0000, 0, 1);
    wr(ga(8), 32'h0000_1234);
    wr(ga(9), 32'h0000_1234);
    wr(OFS_EXT_BASE, 32'h0000_0005);
    wr(OFS_EXT_BASE + 8'h04, 32'h0000_0005);
    flag_case(16'hA811, 0, 16'h0000, 0, 1);
    wr(OFS_EXT_BASE + 8'h04, 32'h0000_0006);
    flag_case(16'hA811, 0, 16'h0000, 1, 0);
    flag_case({5'h14, 3'h0, 2'h2, 6'h05}, 1, 16'h1234, 0, 1);
    flag_case({5'h14, 3'h0, 2'h2, 6'h06}, 1, 16'h1234, 1, 0);
  endtask : t_special

  // Loop zero flags are preset to the wrong value so a missed update shows.
  task cpl_case(input logic [3:0] r, input logic [1:0] m,
                input logic [15:0] v, input logic t);
    logic [16:0] s;
    logic [15:0] ev;
    logic et;
    logic zA;
    logic zB;
    s = {1'b0, ~v} + ((m == 2'h1) ? 17'h1 : (m == 2'h2) ? 17'(t) : 17'h0);
    ev = (m == 2'h3) ? v : s[15:0];
    et = (m == 2'h3) ? t : (m == 2'h0) ? (ev == 16'h0000) : s[16];
    zA = (r == LOOP_REG_A && m != 2'h3) ? ev == 16'h0000 : ev != 16'h0000;
    zB = (r == LOOP_REG_B && m != 2'h3) ? ev == 16'h0000 : ev != 16'h0000;
    wr(ga(r), 32'(v));
    wr(OFS_STATUS, 32'({ev != 16'h0000, ev != 16'h0000, t}));
    exec({6'h23, m, 4'hE, r});
    rd(ga(r), q);
    chk("complement result", 32'(ev), q);
    rd(OFS_STATUS, q);
    chk("complement flags", 32'({zB, zA, et}), 32'(q[2:0]));
  endtask : cpl_case

  // Issues only use commands of 0x200 and up.
  task t_issue(input logic [12:0] cmd);
    int n0;
    n0 = issueCount;
    exec({3'h7, cmd});
    // Look in mid-cycle: at the edge itself the pulse is still being retired.
    @(negedge clk_sys);
    chk("command bus", 32'(cmd), 32'(cmdBus));
    chk("strobe released", 32'h0000_0001, 32'(cmdStrobe_n));
    @(posedge clk_sys);
    rd(OFS_CMD, q);
    chk("command register", 32'(cmd), q);
    chk("strobe cycles", 32'(n0 + 1), 32'(issueCount));
    chk("taken command", 32'(cmd), 32'(lastCmd));
    rd(OFS_STATUS, q);
    chk("condition lines", 32'(4'h1 << cmd[1:0]), 32'(q[7:4]));
  endtask : t_issue

  // Hang guard well above the length of the whole sequence.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  // Main sequence.
  initial begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    repeat (12) @(posedge clk_sys);
    chk("reset wait", 32'h0000_0001, 32'(waitrequest));
    chk("reset strobe", 32'h0000_0001, 32'(cmdStrobe_n));
    chk("reset bus", 32'h0000_0000, 32'(cmdBus));
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_compare();
    t_special();
    cpl_case(4'h6, 2'h0, 16'hFFFF, 1'b0);
    cpl_case(4'h6, 2'h1, 16'h0000, 1'b0);
    cpl_case(4'h7, 2'h1, 16'h0001, 1'b1);
    cpl_case(4'h6, 2'h2, 16'h0000, 1'b1);
    cpl_case(4'h7, 2'h2, 16'h0000, 1'b0);
    cpl_case(4'h2, 2'h2, 16'h1234, 1'b1);
    cpl_case(4'h6, 2'h3, 16'h0000, 1'b1);
    t_issue(13'h0200);
    t_issue(13'h1FFF);
    t_issue(13'h0201);
    end_sim();
  end
endmodule : compare_complement_coproc_issue_bench
